// File: rffs_pkg.sv
// Purpose: shared constants for the raster frame fetch and subpanel engine
// Assumes: 32-bit apb register bus, byte addresses, one aligned word per register
// Notes:   blanking widths are fixed here; only active width and height are programmable
package rffs_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STAT     = 12'h004;
    localparam logic [11:0] OFS_INT_STAT = 12'h008;
    localparam logic [11:0] OFS_INT_MASK = 12'h00c;
    localparam logic [11:0] OFS_FB0_BASE = 12'h010;
    localparam logic [11:0] OFS_FB0_SIZE = 12'h014;
    localparam logic [11:0] OFS_FB1_BASE = 12'h018;
    localparam logic [11:0] OFS_FB1_SIZE = 12'h01c;
    localparam logic [11:0] OFS_SUB_CFG  = 12'h020;
    localparam logic [11:0] OFS_SUB_COL  = 12'h024;
    localparam logic [11:0] OFS_GEOM     = 12'h028;
    localparam logic [11:0] OFS_PIXDIV   = 12'h02c;
    // control and subpanel config bit positions
    localparam int CTRL_RASTER_EN   = 0;
    localparam int CTRL_MODE_RASTER = 1;
    localparam int CTRL_ACTIVE_MTX  = 2;
    localparam int CTRL_DUAL_BUF    = 3;
    localparam int CTRL_PIX_ONLY    = 4;
    localparam int CTRL_SUB_EN      = 5;
    localparam int CTRL_DIRECT_24   = 6;
    localparam int SUB_REGION_LOWER = 16;
    // interrupt status bit positions
    localparam int INT_FRAME_DONE = 0;
    localparam int INT_UNDERFLOW  = 1;
    localparam int INT_PAL_LOADED = 2;
    // reset values
    localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
    localparam logic [10:0] RST_WIDTH  = 11'h320;
    localparam logic [10:0] RST_HEIGHT = 11'h1e0;
    localparam logic [7:0]  RST_PIXDIV = 8'h04;
    // palette header
    localparam logic [7:0] HDR_WORDS_SMALL = 8'h08;
    localparam logic [7:0] HDR_WORDS_LARGE = 8'h80;
    localparam int         TYPE_LSB        = 12;
    // blanking in pixel clocks and lines
    localparam logic [10:0] H_FRONT = 11'h002;
    localparam logic [10:0] H_SYNC  = 11'h008;
    localparam logic [10:0] H_BACK  = 11'h01e;
    localparam logic [10:0] V_FRONT = 11'h00a;
    localparam logic [10:0] V_SYNC  = 11'h002;
    localparam logic [10:0] V_BACK  = 11'h00a;

    typedef enum logic [2:0] {
        lut_type_one_bit    = 3'b000,
        lut_type_two_bit    = 3'b001,
        lut_type_four_bit   = 3'b010,
        lut_type_eight_bit  = 3'b011,
        lut_type_true_colour = 3'b100
    } rffs_lut_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR  = 2'b01,
        ST_SCAN = 2'b10
    } rffs_state_e;
endpackage : rffs_pkg

// File: rffs_raster_engine.sv
// Purpose: raster output engine: frame fetch, palette header, ping-pong buffers, subpanel
// Assumes: memory read port answers one request at a time with a one-cycle ack
// Notes:   the pixel clock is divided from core_clk and runs only while frames are scanned
// Behaviour
// R1: disable stops only after current frame ends
// R2: host waits frame-complete before re-enable
// R3: enable starts scanning configured frame buffer
// R4: host programs everything before enabling
// R5: enable state readable by host
// R6: two buffers; buffer one only alternating
// R7: host keeps buffers word aligned
// R8: pixels-only skips header, else 8/128 words
// R9: eight-bit type takes 128 header words
// R10: pixel type taken from first entry
// R11: two 12-bit entries per word
// R12: type codes select palette entry count
// R13: default colour fills band, no fetch
// R14: subpanel only raster active-matrix mode
// R15: bottom count sets lower band height
// R16: separate enable activates the subpanel
// R17: host resizes buffer around subpanel use
// R18: frame-complete event each finished frame
// R19: enable readback follows last write
`timescale 1ns/1ps
`default_nettype none
module rffs_raster_engine
    import rffs_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             pix_clk,
    output logic             hsync,
    output logic             vsync,
    output logic             data_en,
    output logic      [23:0] pix_data
);
    logic [31:0]  ctrl;
    logic [2:0]   int_stat;
    logic [2:0]   int_mask;
    logic [31:0]  fb_base [2];
    logic [31:0]  fb_size [2];
    logic [10:0]  sub_lines;
    logic         sub_lower;
    logic [23:0]  sub_colour;
    logic [10:0]  width;
    logic [10:0]  height;
    logic [7:0]   pixdiv;
    logic [11:0]  palette [256];
    rffs_state_e  state;
    rffs_lut_e    lut_type;
    logic         cur_buf;
    logic [7:0]   hdr_cnt;
    logic [31:0]  fetch_addr;
    logic [31:0]  fetch_end;
    logic [31:0]  cur_word;
    logic         cur_valid;
    logic [5:0]   bit_pos;
    logic [31:0]  next_word;
    logic         next_valid;
    logic [7:0]   div_cnt;
    logic [10:0]  h_cnt;
    logic [10:0]  v_cnt;
    logic         ev_frame;
    logic         ev_under;
    logic         ev_pal;

    // apb access decode
    logic wr_acc;
    logic rd_hit;
    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= OFS_PIXDIV);
    endfunction : mapped

    assign pslverr = psel & penable & ~mapped(paddr);
    assign rd_hit  = psel & ~penable & ~pwrite;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl       <= RST_CTRL;
            int_mask   <= 3'h0;
            fb_base[0] <= 32'h0;
            fb_base[1] <= 32'h0;
            fb_size[0] <= 32'h0;
            fb_size[1] <= 32'h0;
            sub_lines  <= 11'h0;
            sub_lower  <= 1'b0;
            sub_colour <= 24'h0;
            width      <= RST_WIDTH;
            height     <= RST_HEIGHT;
            pixdiv     <= RST_PIXDIV;
        end else if (wr_acc) begin
            case (paddr)
                OFS_CTRL:     ctrl <= pwdata;          // [R19]
                OFS_INT_MASK: int_mask <= pwdata[2:0];
                OFS_FB0_BASE: fb_base[0] <= pwdata;    // [R6]
                OFS_FB0_SIZE: fb_size[0] <= pwdata;
                OFS_FB1_BASE: fb_base[1] <= pwdata;
                OFS_FB1_SIZE: fb_size[1] <= pwdata;
                OFS_SUB_CFG: begin
                    sub_lines <= pwdata[10:0];         // [R15]
                    sub_lower <= pwdata[SUB_REGION_LOWER];
                end
                OFS_SUB_COL:  sub_colour <= pwdata[23:0];
                OFS_GEOM: begin
                    width  <= pwdata[10:0];
                    height <= pwdata[26:16];
                end
                OFS_PIXDIV:   pixdiv <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // read data registered in the setup cycle so it is stable in the access phase
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prdata <= 32'h0;
        end else if (rd_hit) begin
            case (paddr)
                OFS_CTRL:     prdata <= ctrl;           // [R5] [R19]
                OFS_STAT:     prdata <= {25'h0, lut_type, 2'b0, cur_buf, (state != ST_IDLE)};
                OFS_INT_STAT: prdata <= {29'h0, int_stat};
                OFS_INT_MASK: prdata <= {29'h0, int_mask};
                OFS_FB0_BASE: prdata <= fb_base[0];
                OFS_FB0_SIZE: prdata <= fb_size[0];
                OFS_FB1_BASE: prdata <= fb_base[1];
                OFS_FB1_SIZE: prdata <= fb_size[1];
                OFS_SUB_CFG:  prdata <= {15'h0, sub_lower, 5'h0, sub_lines};
                OFS_SUB_COL:  prdata <= {8'h0, sub_colour};
                OFS_GEOM:     prdata <= {5'h0, height, 5'h0, width};
                OFS_PIXDIV:   prdata <= {24'h0, pixdiv};
                default:      prdata <= 32'h0;
            endcase
        end
    end

    // sticky events: a new event wins over a write-one clear in the same cycle
    logic [2:0] ev_vec;
    logic [2:0] clr_vec;
    assign ev_vec  = {ev_pal, ev_under, ev_frame};
    assign clr_vec = (wr_acc && paddr == OFS_INT_STAT) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            int_stat <= 3'h0;
        end else begin
            int_stat <= (int_stat & ~clr_vec) | ev_vec;
        end
    end
    assign irq = |(int_stat & int_mask);

    // pixel clock divider, minimum ratio of two
    logic [7:0] div_eff;
    logic       tick;
    assign div_eff = (pixdiv < 8'h02) ? 8'h02 : pixdiv;
    assign tick    = (state == ST_SCAN) && (div_cnt == div_eff - 8'h01);
    always_ff @(posedge core_clk) begin
        if (!resetn || state != ST_SCAN) begin
            div_cnt <= 8'h0;
            pix_clk <= 1'b0;
        end else begin
            div_cnt <= tick ? 8'h0 : div_cnt + 8'h01;
            pix_clk <= !tick && (div_cnt + 8'h01 >= (div_eff >> 1));
        end
    end

    // timing geometry
    logic [10:0] h_total;
    logic [10:0] v_total;
    logic        line_end;
    logic        frame_end;
    assign h_total   = width + H_FRONT + H_SYNC + H_BACK;
    assign v_total   = height + V_FRONT + V_SYNC + V_BACK;
    assign line_end  = tick && (h_cnt == h_total - 11'h001);
    assign frame_end = line_end && (v_cnt == v_total - 11'h001);

    // subpanel band decision
    logic        sub_on;
    logic        default_line;
    logic [10:0] split;
    assign sub_on = ctrl[CTRL_SUB_EN] & ctrl[CTRL_MODE_RASTER] & ctrl[CTRL_ACTIVE_MTX]; // [R14] [R16]
    assign split  = height - sub_lines;                                                  // [R15]
    assign default_line = sub_on && (sub_lower ? (v_cnt < split) : (v_cnt >= split));

    // pixel unpacking: log2 of bits per pixel
    function automatic logic [2:0] bpp_log(input rffs_lut_e t, input logic d24);
        case (t)
            lut_type_one_bit:   bpp_log = 3'd0;
            lut_type_two_bit:   bpp_log = 3'd1;
            lut_type_four_bit:  bpp_log = 3'd2;
            lut_type_eight_bit: bpp_log = 3'd3;
            default:            bpp_log = d24 ? 3'd5 : 3'd4;                           // [R12]
        endcase
    endfunction : bpp_log

    logic [5:0]  bpp;
    logic [31:0] src_word;
    logic [5:0]  src_pos;
    logic        have_pix;
    logic [31:0] shifted;
    logic [31:0] pix_val;
    logic [31:0] pix_mask;
    logic        in_active;
    logic        consume;
    logic [6:0]  pos_sum;
    logic [11:0] lut_col;
    logic [23:0] colour;
    assign bpp       = 6'd1 << bpp_log(lut_type, ctrl[CTRL_DIRECT_24]);
    assign src_word  = cur_valid ? cur_word : next_word;
    assign src_pos   = cur_valid ? bit_pos : 6'd0;
    assign have_pix  = cur_valid | next_valid;
    assign shifted   = src_word >> src_pos;
    assign pix_mask  = (bpp == 6'd32) ? 32'hffff_ffff : ((32'h1 << bpp) - 32'h1);
    assign pix_val   = shifted & pix_mask;
    assign in_active = (h_cnt < width) && (v_cnt < height);
    assign consume   = tick && in_active && !default_line;                             // [R13]
    assign pos_sum   = {1'b0, src_pos} + {1'b0, bpp};
    assign lut_col   = palette[pix_val[7:0]];

    always_comb begin
        if (lut_type != lut_type_true_colour) begin
            colour = {lut_col[11:8], lut_col[11:8], lut_col[7:4], lut_col[7:4], lut_col[3:0], lut_col[3:0]};
        end else if (ctrl[CTRL_DIRECT_24]) begin
            colour = pix_val[23:0];
        end else begin
            colour = {pix_val[15:11], pix_val[15:13], pix_val[10:5], pix_val[10:9], pix_val[4:0], pix_val[4:2]};
        end
    end

    // frame sequencing
    logic        buf_sel;
    logic [7:0]  hdr_len;
    logic        hdr_last;
    assign buf_sel  = ctrl[CTRL_DUAL_BUF] ? ~cur_buf : 1'b0;                           // [R6]
    assign hdr_len  = (lut_type == lut_type_eight_bit) ? HDR_WORDS_LARGE : HDR_WORDS_SMALL; // [R9]
    assign hdr_last = (hdr_cnt != 8'h0) && (hdr_cnt == hdr_len - 8'h01);
    assign mem_req  = (state == ST_HDR) ||
                      (state == ST_SCAN && !next_valid && fetch_addr < fetch_end);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state      <= ST_IDLE;
            cur_buf    <= 1'b1;
            hdr_cnt    <= 8'h0;
            fetch_addr <= 32'h0;
            fetch_end  <= 32'h0;
            lut_type   <= lut_type_true_colour;
            ev_pal     <= 1'b0;
        end else begin
            ev_pal <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (ctrl[CTRL_RASTER_EN]) begin                                     // [R3]
                        cur_buf    <= 1'b0;
                        hdr_cnt    <= 8'h0;
                        fetch_addr <= fb_base[0];
                        fetch_end  <= fb_base[0] + fb_size[0];
                        state      <= ctrl[CTRL_PIX_ONLY] ? ST_SCAN : ST_HDR;           // [R8]
                    end
                end
                ST_HDR: begin
                    if (mem_ack) begin
                        fetch_addr <= fetch_addr + 32'h4;
                        hdr_cnt    <= hdr_cnt + 8'h01;
                        if (hdr_cnt == 8'h0) begin
                            lut_type <= rffs_lut_e'(mem_rdata[TYPE_LSB +: 3]);          // [R10]
                        end
                        if (hdr_last) begin
                            ev_pal <= 1'b1;
                            state  <= ST_SCAN;
                        end
                    end
                end
                ST_SCAN: begin
                    if (mem_ack) begin
                        fetch_addr <= fetch_addr + 32'h4;
                    end
                    if (frame_end) begin
                        // a disable only takes effect here, at the frame boundary
                        if (!ctrl[CTRL_RASTER_EN]) begin                                 // [R1]
                            state <= ST_IDLE;
                        end else begin
                            cur_buf    <= buf_sel;
                            hdr_cnt    <= 8'h0;
                            fetch_addr <= fb_base[buf_sel];
                            fetch_end  <= fb_base[buf_sel] + fb_size[buf_sel];
                            state      <= ctrl[CTRL_PIX_ONLY] ? ST_SCAN : ST_HDR;       // [R8]
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    assign mem_addr = fetch_addr;

    // palette header: two 12-bit entries per word, low half first
    always_ff @(posedge core_clk) begin
        if (state == ST_HDR && mem_ack) begin
            palette[{hdr_cnt[6:0], 1'b0}] <= mem_rdata[11:0];                           // [R11]
            palette[{hdr_cnt[6:0], 1'b1}] <= mem_rdata[27:16];
        end
    end

    // word buffer: one word in use and one prefetched ahead of the scan
    always_ff @(posedge core_clk) begin
        if (!resetn || state != ST_SCAN || frame_end) begin
            cur_word   <= 32'h0;
            cur_valid  <= 1'b0;
            bit_pos    <= 6'd0;
            next_word  <= 32'h0;
            next_valid <= 1'b0;
        end else begin
            if (mem_ack) begin
                next_word  <= mem_rdata;
                next_valid <= 1'b1;
            end
            if (consume && have_pix) begin
                if (!cur_valid) begin
                    cur_word   <= next_word;
                    next_valid <= 1'b0;
                end
                cur_valid <= ~pos_sum[6] & (pos_sum[5:0] != 6'd32);
                bit_pos   <= pos_sum[5:0];
            end
        end
    end

    // scan counters and panel outputs
    always_ff @(posedge core_clk) begin
        if (!resetn || state != ST_SCAN) begin
            h_cnt    <= 11'h0;
            v_cnt    <= 11'h0;
            hsync    <= 1'b0;
            vsync    <= 1'b0;
            data_en  <= 1'b0;
            pix_data <= 24'h0;
            ev_frame <= 1'b0;
            ev_under <= 1'b0;
        end else begin
            ev_frame <= frame_end;                                                      // [R18]
            ev_under <= consume && !have_pix;
            if (tick) begin
                h_cnt   <= line_end ? 11'h0 : h_cnt + 11'h001;
                v_cnt   <= frame_end ? 11'h0 : (line_end ? v_cnt + 11'h001 : v_cnt);
                data_en <= in_active;
                hsync   <= (h_cnt >= width + H_FRONT) && (h_cnt < width + H_FRONT + H_SYNC);
                vsync   <= (v_cnt >= height + V_FRONT) && (v_cnt < height + V_FRONT + V_SYNC);
                if (!in_active) begin
                    pix_data <= 24'h0;
                end else if (default_line) begin
                    pix_data <= sub_colour;                                             // [R13]
                end else begin
                    pix_data <= have_pix ? colour : 24'h0;
                end
            end
        end
    end
endmodule : rffs_raster_engine
`default_nettype wire

// File: rffs_raster_engine_asserts.sv
// Purpose: port-level assertions for the raster fetch engine
// Assumes: zero-wait apb slave, byte addresses
// Notes:   only the enable bit of the control word is shadowed here
`timescale 1ns/1ps
`default_nettype none
module rffs_raster_engine_asserts
    import rffs_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        pix_clk,
    input wire logic        hsync,
    input wire logic        vsync,
    input wire logic        data_en,
    input wire logic [23:0] pix_data
);
    logic acc;
    logic en_shadow;
    assign acc = psel && penable;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            en_shadow <= 1'b0;
        end else if (acc && pwrite && paddr == OFS_CTRL) begin
            en_shadow <= pwdata[CTRL_RASTER_EN];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_ready_high: assert property (psel |-> pready) else $error("pready low");
    a_bad_addr: assert property (acc && (paddr > OFS_PIXDIV || paddr[1:0] != 2'b00) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_good_addr: assert property (acc && paddr <= OFS_PIXDIV && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_en_readback: assert property (acc && !pwrite && paddr == OFS_CTRL |-> prdata[0] == en_shadow)
        else $error("enable readback wrong");
    a_fetch_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("fetch request dropped");
    a_blank_black: assert property (!data_en |-> pix_data == 24'h0) else $error("pixel outside active area");
    a_sync_blank: assert property (data_en |-> !hsync && !vsync) else $error("sync during active video");
    a_irq_cause: assert property ($rose(irq) |-> $past(acc && pwrite) || $past(mem_ack, 2) || $past(pix_clk, 2))
        else $error("irq rose without cause");
endmodule : rffs_raster_engine_asserts
bind rffs_raster_engine rffs_raster_engine_asserts u_chk (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pix_clk(pix_clk),
    .hsync(hsync), .vsync(vsync), .data_en(data_en), .pix_data(pix_data));
`default_nettype wire

// File: rffs_mem_model.sv
// Purpose: frame buffer memory answering the engine's word fetches
// Assumes: buffers start on 4 KiB boundaries, so word 0 is the header type word
// Notes:   data bus toggles between answers so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module rffs_mem_model (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [2:0]  lut,
    input  wire logic [3:0]  delay,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [3:0] wait_cnt;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_cnt  <= 4'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= delay) begin
            mem_ack   <= 1'b1;
            wait_cnt  <= 4'h0;
            if (mem_addr[11:0] == 12'h000) begin
                mem_rdata <= {17'h0, lut, 12'h000};
            end else begin
                mem_rdata <= {4'h0, mem_addr[11:0], 4'h0, ~mem_addr[11:0]};
            end
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : rffs_mem_model
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the raster fetch engine
// Assumes: 32x2 image, pixel divider 2, buffers at 0x1000 and 0x8000
// Notes:   run_frame starts and disables each frame at once, so exactly one frame runs; t_dual runs two frames
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rffs_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  lut = 3'h4;
    logic [3:0]  delay = 4'h0;
    logic [31:0] prdata, mem_addr, mem_rdata, rd;
    logic        pready, pslverr, irq, mem_req, mem_ack, pix_clk, hsync, vsync, data_en, err;
    logic [23:0] pix_data;
    logic        got_first = 1'b0, first_col = 1'b0, seen_col = 1'b0, seen_fb1 = 1'b0, seen_clk = 1'b0;
    int          mismatches = 0, num_checks = 0, acks = 0, cycles = 0, n;
    localparam logic [23:0] COLOUR = 24'h123457;
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    rffs_raster_engine dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync), .data_en(data_en), .pix_data(pix_data));
    rffs_mem_model u_mem (.core_clk(core_clk), .resetn(resetn), .mem_req(mem_req), .mem_addr(mem_addr),
        .lut(lut), .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always @(posedge core_clk) begin
        cycles++;
        if (mem_ack === 1'b1) begin
            acks++;
            if (mem_addr >= 32'h8000) seen_fb1 = 1'b1;
        end
        if (pix_clk === 1'b1) seen_clk = 1'b1;
        if (data_en === 1'b1) begin
            if (pix_data === COLOUR) seen_col = 1'b1;
            if (!got_first) first_col = (pix_data === COLOUR);
            got_first = 1'b1;
        end
        if (cycles == 80000) begin
            mismatches++;
            finish_test();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 9000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 9000) chk(32'h0, 32'h1);
    endtask : wait_irq
    task run_frame(input logic [31:0] ctrl, input logic [2:0] l, input int exp);
        lut <= l;
        acks = 0;
        got_first = 1'b0;
        seen_col = 1'b0;
        apb(1'b1, OFS_FB0_SIZE, 32'(exp * 4));
        apb(1'b1, OFS_CTRL, ctrl | 32'h1);
        apb(1'b1, OFS_CTRL, ctrl);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, ctrl);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[0]), 32'h1);
        wait_irq();
        chk(32'(acks), 32'(exp));
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[0]), 32'h0);
        if (!ctrl[CTRL_PIX_ONLY]) chk(32'(rd[6:4]), 32'(l));
        apb(1'b1, OFS_INT_STAT, 32'h7);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
    endtask : run_frame
    task t_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, RST_CTRL);
        apb(1'b0, OFS_GEOM, 32'h0);
        chk(rd, {5'h0, RST_HEIGHT, 5'h0, RST_WIDTH});
        apb(1'b0, OFS_PIXDIV, 32'h0);
        chk(rd, {24'h0, RST_PIXDIV});
        apb(1'b0, 12'h030, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, OFS_FB1_BASE, 32'h8000);
        apb(1'b0, OFS_FB1_BASE, 32'h0);
        chk(rd, 32'h8000);
        apb(1'b1, OFS_FB0_BASE, 32'h1000);
        apb(1'b1, OFS_GEOM, {5'h0, 11'h002, 5'h0, 11'h020});
        apb(1'b1, OFS_PIXDIV, 32'h2);
        apb(1'b1, OFS_INT_MASK, 32'h1);
        apb(1'b1, OFS_SUB_CFG, 32'h1);
        apb(1'b1, OFS_SUB_COL, {8'h0, COLOUR});
        $display("regs test done, mismatches %0d", mismatches);
    endtask : t_regs
    task t_lut;
        for (int i = 0; i < 5; i++) begin
            run_frame(32'h6, 3'(i), (i == 3 ? 128 : 8) + 2 * (1 << i));
            chk({seen_col, seen_fb1}, 32'h0);
        end
        run_frame(32'h16, 3'h4, 32);
        $display("lut test done, mismatches %0d", mismatches);
    endtask : t_lut
    task t_sub;
        run_frame(32'h26, 3'h4, 24);
        chk({seen_col, first_col}, 32'h2);
        apb(1'b1, OFS_SUB_CFG, 32'h0001_0001);
        run_frame(32'h26, 3'h4, 24);
        chk({seen_col, first_col}, 32'h3);
        run_frame(32'h22, 3'h4, 40);
        chk(32'(seen_col), 32'h0);
        run_frame(32'h06, 3'h4, 40);
        chk(32'(seen_col), 32'h0);
        $display("subpanel test done, mismatches %0d", mismatches);
    endtask : t_sub
    task t_dual;
        delay <= 4'h1;
        acks = 0;
        apb(1'b1, OFS_FB0_SIZE, 32'd160);
        apb(1'b1, OFS_FB1_SIZE, 32'd160);
        apb(1'b1, OFS_CTRL, 32'hf);
        wait_irq();
        apb(1'b1, OFS_INT_MASK, 32'h0);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_INT_MASK, 32'h1);
        @(posedge core_clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_INT_STAT, 32'h7);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_CTRL, 32'he);
        wait_irq();
        chk({seen_fb1, 7'(acks)}, {1'b1, 7'd80});
        chk(32'(seen_clk), 32'h1);
        $display("dual buffer test done, mismatches %0d", mismatches);
    endtask : t_dual
    task finish_test;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_lut();
        t_sub();
        t_dual();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
